// *** verilog/asc_conv_ctrl.sv ***
// Purpose: Conversion sequencing, control word capture and result shifting
// Assumes: SAR comparator and analog mux sit outside; all pins are asynchronous
// Notes:   Results also leave through a small FIFO for on-chip consumers
`timescale 1ns/10ps
`default_nettype none

module asc_fifo #(
    parameter int W     = 15,
    parameter int DEPTH = 4
) (
    input  wire logic         clock_i,
    input  wire logic         sys_rst_i,
    input  wire logic         in_valid_i,
    input  wire logic [W-1:0] in_data_i,
    output logic              in_ready_o,
    output logic              out_valid_o,
    output logic [W-1:0]      out_data_o,
    input  wire logic         out_ready_i
);
    logic [DEPTH-1:0] vld_reg;
    logic [DEPTH-1:0] vld_next;
    logic [W-1:0]     mem_reg  [DEPTH];
    logic [W-1:0]     mem_next [DEPTH];
    logic             pop;
    logic             push;
    logic             placed;

    if (DEPTH < 2) begin : g_bad_depth
        $error("asc_fifo needs a depth of at least two");
    end

    // Shift-register FIFO: head always sits in entry 0, so outputs are flops
    always_comb begin
        placed = 1'b0;
        pop    = out_ready_i & vld_reg[0];
        push   = in_valid_i & ~vld_reg[DEPTH-1];
        for (int i = 0; i < DEPTH; i++) begin
            if (pop) begin
                vld_next[i] = (i < DEPTH-1) ? vld_reg[i+1] : 1'b0;
                mem_next[i] = (i < DEPTH-1) ? mem_reg[i+1] : mem_reg[i];
            end else begin
                vld_next[i] = vld_reg[i];
                mem_next[i] = mem_reg[i];
            end
        end
        for (int i = 0; i < DEPTH; i++) begin
            if (push && !placed && !vld_next[i]) begin
                vld_next[i] = 1'b1;
                mem_next[i] = in_data_i;
                placed      = 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            vld_reg <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= '0;
            end
        end else begin
            vld_reg <= vld_next;
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= mem_next[i];
            end
        end
    end

    assign in_ready_o  = ~vld_reg[DEPTH-1];
    assign out_valid_o = vld_reg[0];
    assign out_data_o  = mem_reg[0];
endmodule

module asc_conv_ctrl (
    input  wire logic            clock_i,
    input  wire logic            sys_rst_i,
    input  wire logic            cs_n_i,
    input  wire logic            sclk_i,
    input  wire logic            din_i,
    input  wire logic            cmp_i,
    input  wire logic            res_ready_i,
    output logic                 dout_o,
    output logic                 dout_oe_n_o,
    output logic                 power_up_o,
    output logic                 track_o,
    output logic [6:0]           ain_sel_o,
    output logic                 gnd_sel_o,
    output logic [11:0]          dac_code_o,
    output logic                 res_valid_o,
    output asc_pkg::asc_result_t res_data_o,
    output logic                 res_full_o,
    output logic                 overrun_o
);
    localparam int RW = $bits(asc_pkg::asc_result_t);

    logic [1:0] cs_sy, sclk_sy, din_sy, cmp_sy;
    logic       cs_d, sclk_d;
    logic       cs_s, sclk_s, din_s, cmp_s;
    logic       cs_fall, sclk_fall, sclk_rise, int_fall, first;

    asc_pkg::asc_state_t        state_reg, state_next;
    logic [asc_pkg::CNT_W-1:0]  fall_reg, fall_next, fnum;
    logic [asc_pkg::CNT_W-1:0]  rise_reg, rise_next, rbase;
    logic [7:0]                 shift_reg, shift_next;
    logic [7:0]                 channel_select_control_word_reg, ctrl_next;
    logic [2:0]                 chan_reg, chan_next;
    logic [11:0]                sar_reg, sar_next;
    logic                       dout_reg, dout_next, oe_n_reg, oe_n_next;
    logic                       pend_reg, pend_next, ovr_reg, ovr_next, push_evt;
    asc_pkg::asc_result_t       pend_data_reg, pend_data_next;
    logic [6:0]                 ain_reg;
    logic                       gnd_reg, track_reg, pwr_reg, full_reg;
    logic [3:0]                 bidx;
    logic                       fifo_ready, take;

    // Channel code to mux selects; ground code leaves all inputs open
    function automatic logic [6:0] ain_decode(input logic [2:0] code);
        if (code == asc_pkg::GND_CODE) begin
            return asc_pkg::AIN_NONE;
        end
        return 7'(asc_pkg::AIN_FIRST << code);
    endfunction

    // Two flops on the frame, clock, data and comparator pins before anything looks at them
    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cs_sy   <= 2'h3;
            sclk_sy <= 2'h0;
            din_sy  <= 2'h0;
            cmp_sy  <= 2'h0;
            cs_d    <= 1'b1;
            sclk_d  <= 1'b0;
        end else begin
            cs_sy   <= {cs_sy[0], cs_n_i};
            sclk_sy <= {sclk_sy[0], sclk_i};
            din_sy  <= {din_sy[0], din_i};
            cmp_sy  <= {cmp_sy[0], cmp_i};
            cs_d    <= cs_sy[1];
            sclk_d  <= sclk_sy[1];
        end
    end

    assign cs_s      = cs_sy[1];
    assign sclk_s    = sclk_sy[1];
    assign din_s     = din_sy[1];
    assign cmp_s     = cmp_sy[1];
    assign cs_fall   = cs_d & ~cs_s;
    assign sclk_fall = sclk_d & ~sclk_s;
    assign sclk_rise = ~sclk_d & sclk_s;
    // Clock is gated by frame select, so a frame start with clock low is a fall
    assign int_fall  = ~cs_s & (sclk_fall | (cs_fall & ~sclk_s));
    assign first     = cs_fall | (state_reg == asc_pkg::ST_ARM) | (state_reg == asc_pkg::ST_DOWN);
    assign take      = pend_reg & fifo_ready;

    // Conversion sequencer, control word shifter and SAR register
    always_comb begin
        state_next     = state_reg;
        fall_next      = fall_reg;
        rise_next      = rise_reg;
        shift_next     = shift_reg;
        ctrl_next      = channel_select_control_word_reg;
        chan_next      = chan_reg;
        sar_next       = sar_reg;
        dout_next      = dout_reg;
        oe_n_next      = oe_n_reg;
        push_evt       = 1'b0;
        fnum           = first ? asc_pkg::FALL_TRACK : 5'(fall_reg + 5'h01);
        rbase          = cs_fall ? '0 : rise_reg;
        bidx           = 4'(asc_pkg::FALL_LAST - fnum);
        if (cs_s) begin
            state_next = asc_pkg::ST_IDLE;
            oe_n_next  = 1'b1;
            dout_next  = 1'b0;
            fall_next  = '0;
            rise_next  = '0;
        end else begin
            if (cs_fall) begin
                state_next = asc_pkg::ST_ARM;
                oe_n_next  = 1'b0;
                dout_next  = 1'b0;
                fall_next  = '0;
                rise_next  = '0;
                chan_next  = channel_select_control_word_reg[asc_pkg::SEL_MSB:asc_pkg::SEL_LSB];
            end
            if (int_fall) begin
                fall_next = fnum;
                if (fnum < asc_pkg::FALL_HOLD) begin
                    state_next = asc_pkg::ST_TRACK;
                    sar_next   = '0;
                    dout_next  = 1'b0;
                    // Rise count restarts at fall one; rise 16 still follows fall 16
                    if (fnum == asc_pkg::FALL_TRACK) begin
                        rise_next = '0;
                    end
                end else if (fnum == asc_pkg::FALL_HOLD) begin
                    state_next = asc_pkg::ST_HOLD;
                    sar_next   = asc_pkg::SAR_MSB;
                    dout_next  = 1'b0;
                end else begin
                    // Straight binary SAR: keep the trial bit when input is above it
                    sar_next[bidx] = cmp_s;
                    if (bidx != 4'h0) begin
                        sar_next[bidx - 4'h1] = 1'b1;
                    end
                    dout_next = cmp_s;
                    if (fnum == asc_pkg::FALL_LAST) begin
                        state_next = asc_pkg::ST_DOWN;
                        push_evt   = 1'b1;
                        chan_next  = channel_select_control_word_reg[asc_pkg::SEL_MSB:asc_pkg::SEL_LSB];
                    end
                end
            end
            if (sclk_rise && state_next != asc_pkg::ST_IDLE && rbase < asc_pkg::RISE_LAST) begin
                rise_next = 5'(rbase + 5'h01);
                if (rbase < asc_pkg::RISE_CTRL) begin
                    shift_next = {shift_reg[6:0], din_s};
                    if (rise_next == asc_pkg::RISE_CTRL) begin
                        ctrl_next = {shift_reg[6:0], din_s};
                    end
                end
            end
        end
    end

    // Result hand-off: one pending word, lost only if the FIFO stays full
    always_comb begin
        pend_next      = pend_reg;
        pend_data_next = pend_data_reg;
        ovr_next       = ovr_reg;
        if (take) begin
            pend_next = 1'b0;
        end
        if (push_evt) begin
            ovr_next       = ovr_reg | (pend_reg & ~take);
            pend_next      = 1'b1;
            pend_data_next = '{chan: chan_reg, code: sar_next};
        end
    end

    always_ff @(posedge clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_reg                       <= asc_pkg::ST_IDLE;
            fall_reg                        <= '0;
            rise_reg                        <= '0;
            shift_reg                       <= asc_pkg::CTRL_RESET;
            channel_select_control_word_reg <= asc_pkg::CTRL_RESET;
            chan_reg                        <= '0;
            sar_reg                         <= '0;
            dout_reg                        <= 1'b0;
            oe_n_reg                        <= 1'b1;
            pend_reg                        <= 1'b0;
            pend_data_reg                   <= '0;
            ovr_reg                         <= 1'b0;
            ain_reg                         <= asc_pkg::AIN_FIRST;
            gnd_reg                         <= 1'b0;
            track_reg                       <= 1'b0;
            pwr_reg                         <= 1'b0;
            full_reg                        <= 1'b0;
        end else begin
            state_reg                       <= state_next;
            fall_reg                        <= fall_next;
            rise_reg                        <= rise_next;
            shift_reg                       <= shift_next;
            channel_select_control_word_reg <= ctrl_next;
            chan_reg                        <= chan_next;
            sar_reg                         <= sar_next;
            dout_reg                        <= dout_next;
            oe_n_reg                        <= oe_n_next;
            pend_reg                        <= pend_next;
            pend_data_reg                   <= pend_data_next;
            ovr_reg                         <= ovr_next;
            ain_reg                         <= ain_decode(chan_next);
            gnd_reg                         <= (chan_next == asc_pkg::GND_CODE);
            track_reg                       <= (state_next == asc_pkg::ST_TRACK);
            pwr_reg                         <= (state_next != asc_pkg::ST_IDLE)
                                               && (state_next != asc_pkg::ST_DOWN);
            full_reg                        <= ~fifo_ready;
        end
    end

    asc_fifo #(
        .W     (RW),
        .DEPTH (asc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clock_i     (clock_i),
        .sys_rst_i   (sys_rst_i),
        .in_valid_i  (pend_reg),
        .in_data_i   (pend_data_reg),
        .in_ready_o  (fifo_ready),
        .out_valid_o (res_valid_o),
        .out_data_o  (res_data_o),
        .out_ready_i (res_ready_i)
    );

    assign dout_o      = dout_reg;
    assign dout_oe_n_o = oe_n_reg;
    assign power_up_o  = pwr_reg;
    assign track_o     = track_reg;
    assign ain_sel_o   = ain_reg;
    assign gnd_sel_o   = gnd_reg;
    assign dac_code_o  = sar_reg;
    assign res_full_o  = full_reg;
    assign overrun_o   = ovr_reg;

    property p_track_start;
        @(posedge clock_i) disable iff (sys_rst_i)
        $rose(track_o) |-> fall_reg == asc_pkg::FALL_TRACK;
    endproperty
    a_track_start: assert property (p_track_start) else $error("track began off edge one");

    property p_hold_start;
        @(posedge clock_i) disable iff (sys_rst_i)
        $fell(track_o) && state_reg == asc_pkg::ST_HOLD |-> fall_reg == asc_pkg::FALL_HOLD;
    endproperty
    a_hold_start: assert property (p_hold_start) else $error("hold began off edge four");

    property p_hold_span;
        @(posedge clock_i) disable iff (sys_rst_i)
        state_reg == asc_pkg::ST_HOLD |-> fall_reg >= asc_pkg::FALL_HOLD && fall_reg < asc_pkg::FALL_LAST;
    endproperty
    a_hold_span: assert property (p_hold_span) else $error("hold outside edges four to fifteen");

    property p_auto_down;
        @(posedge clock_i) disable iff (sys_rst_i)
        state_reg == asc_pkg::ST_DOWN |-> fall_reg == asc_pkg::FALL_LAST && !power_up_o;
    endproperty
    a_auto_down: assert property (p_auto_down) else $error("auto power-down wrong");

    property p_cs_power;
        @(posedge clock_i) disable iff (sys_rst_i)
        cs_s |=> !power_up_o;
    endproperty
    a_cs_power: assert property (p_cs_power) else $error("powered with frame high");

    property p_float;
        @(posedge clock_i) disable iff (sys_rst_i)
        cs_s |=> dout_oe_n_o;
    endproperty
    a_float: assert property (p_float) else $error("output driven with frame high");

    property p_lead_zero;
        @(posedge clock_i) disable iff (sys_rst_i)
        state_reg == asc_pkg::ST_TRACK |-> !dout_oe_n_o && !dout_o;
    endproperty
    a_lead_zero: assert property (p_lead_zero) else $error("leading bit not zero");

    property p_ctrl_late;
        @(posedge clock_i) disable iff (sys_rst_i)
        sclk_rise && !cs_fall && rise_reg >= asc_pkg::RISE_CTRL |=> $stable(channel_select_control_word_reg);
    endproperty
    a_ctrl_late: assert property (p_ctrl_late) else $error("control word changed late");

    property p_gnd_sel;
        @(posedge clock_i) disable iff (sys_rst_i)
        gnd_sel_o |-> ain_sel_o == asc_pkg::AIN_NONE && chan_reg == asc_pkg::GND_CODE;
    endproperty
    a_gnd_sel: assert property (p_gnd_sel) else $error("ground select inconsistent");
endmodule

`default_nettype wire

// *** inc/asc_pkg.sv ***
// Purpose: Shared constants and types of the serial conversion control block
// Assumes: Serial clock is sampled by the 10 MHz system clock
// Notes:   Overview list below summarises each behaviour of the block
// Overview of operation
// - Control word bits 7, 6, 2, 1 and 0 are ignored.
// - Bits 5 to 3 pick the channel for the next conversion.
// - Codes 0 to 6 select inputs one to seven; code 7 selects ground.
// - First conversion after power-up samples input one, no dummy cycle.
// - Track mode lasts the first three serial clocks after frame start.
// - Last thirteen serial clocks hold the sample and resolve bits.
// - Powered while frame select is low outside auto power-down, powered down while high.
// - Auto power-down from the 16th falling edge to the next first.
// - Conversions of 16 clocks follow back to back while frame low.
// - Result is straight binary, one LSB is reference over 4096.
// - Control word taken MSB first on first 8 rising edges only.
// - Output drives on frame start: four zeros, then twelve bits MSB first.
// - Track starts at first falling edge, hold starts at the fourth.
// - Control word resets to all zeros, channel code zero.
package asc_pkg;
    localparam int          RES_BITS   = 12;
    localparam int          CTRL_BITS  = 8;
    localparam int          SEL_MSB    = 5;
    localparam int          SEL_LSB    = 3;
    localparam int          CNT_W      = 5;
    localparam int          FIFO_DEPTH = 4;
    localparam logic [4:0]  FALL_TRACK = 5'h01;
    localparam logic [4:0]  FALL_HOLD  = 5'h04;
    localparam logic [4:0]  FALL_LAST  = 5'h10;
    localparam logic [4:0]  RISE_CTRL  = 5'h08;
    localparam logic [4:0]  RISE_LAST  = 5'h10;
    localparam logic [7:0]  CTRL_RESET = 8'h00;
    localparam logic [2:0]  GND_CODE   = 3'h7;
    localparam logic [11:0] SAR_MSB    = 12'h800;
    localparam logic [6:0]  AIN_NONE   = 7'h00;
    localparam logic [6:0]  AIN_FIRST  = 7'h01;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ARM,
        ST_TRACK,
        ST_HOLD,
        ST_DOWN
    } asc_state_t;

    typedef struct packed {
        logic [2:0]          chan;
        logic [RES_BITS-1:0] code;
    } asc_result_t;
endpackage

// *** dv/asc_host_model.sv ***
// Purpose: Behavioural serial host that frames conversions and reads results
// Assumes: Link clock stands still outside frames; pins change just after a system edge
// Notes:   Control words go in and captured words come out through queues
`timescale 1ns/10ps
`default_nettype none

module asc_host_model (
    input  wire logic clock_i,
    input  wire logic dout_i,
    input  wire logic track_i,
    input  wire logic power_up_i,
    output logic      cs_n_o,
    output logic      sclk_o,
    output logic      din_o
);
    logic [7:0]  ctrl_q[$];
    logic [15:0] rx_q[$];
    logic [15:0] trk_q[$];
    logic [15:0] pwr_q[$];

    // Idle: frame select high, link clock parked high
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b1;
        din_o  = 1'b0;
    end

    // Half a link period is four system clocks, 800 ns per period
    task automatic half();
        repeat (4) @(posedge clock_i);
        #1;
    endtask

    // n conversions in one frame; the last stops after last_bits rises
    task automatic run(input int n, input bit low_idle, input int last_bits);
        logic [7:0]  w;
        logic [15:0] sh;
        logic [15:0] tk;
        logic [15:0] pw;
        int          nb;
        sclk_o = ~low_idle;
        half();
        din_o  = ctrl_q[0][7];
        cs_n_o = 1'b0;
        half();
        for (int c = 0; c < n; c++) begin
            w  = ctrl_q.pop_front();
            nb = (c == n - 1) ? last_bits : 16;
            for (int b = 0; b < nb; b++) begin
                // With the clock parked low the frame start stands in for the first fall
                if (!(c == 0 && b == 0 && low_idle)) begin
                    sclk_o = 1'b0;
                    din_o  = (b < 8) ? w[7 - b] : ~din_o;
                end
                half();
                sclk_o = 1'b1;
                sh     = {sh[14:0], dout_i};
                tk     = {tk[14:0], track_i};
                pw     = {pw[14:0], power_up_i};
                half();
            end
            if (nb == 16) begin
                rx_q.push_back(sh);
                trk_q.push_back(tk);
                pwr_q.push_back(pw);
            end
        end
        cs_n_o = 1'b1;
        din_o  = ~din_o;
    endtask
endmodule

`default_nettype wire

// *** dv/tb_top.sv ***
// Purpose: Self-checking bench of the serial conversion control block
// Assumes: Comparator is modelled from a held sample and the trial word
// Notes:   Every scenario is a task; results checked on the pin and the stream
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    logic                 clock_i, sys_rst_i, cs_n, sclk, din, cmp, res_ready, pat;
    logic                 dout_o, dout_oe_n_o, power_up_o, track_o, gnd_sel_o, dout_w;
    logic                 res_valid_o, res_full_o, overrun_o;
    logic [6:0]           ain_sel_o;
    logic [11:0]          dac_code_o;
    logic [11:0]          held = 12'h000;
    logic [2:0]           exp_chan;
    logic [7:0]           wq[$];
    asc_pkg::asc_result_t res_data_o, e;
    asc_pkg::asc_result_t ser_q[$], str_q[$], got_q[$];
    int                   num_errors = 0;
    int                   tests_run = 0;

    asc_conv_ctrl dut_u (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i), .cs_n_i(cs_n), .sclk_i(sclk),
        .din_i(din), .cmp_i(cmp), .res_ready_i(res_ready), .dout_o(dout_o),
        .dout_oe_n_o(dout_oe_n_o), .power_up_o(power_up_o), .track_o(track_o),
        .ain_sel_o(ain_sel_o), .gnd_sel_o(gnd_sel_o), .dac_code_o(dac_code_o),
        .res_valid_o(res_valid_o), .res_data_o(res_data_o), .res_full_o(res_full_o),
        .overrun_o(overrun_o));

    asc_host_model host_u (
        .clock_i(clock_i), .dout_i(dout_w), .track_i(track_o), .power_up_i(power_up_o),
        .cs_n_o(cs_n), .sclk_o(sclk), .din_o(din));

    // Input levels per channel; boundaries chosen to expose bit slips
    function automatic logic [11:0] level(input logic [2:0] ch);
        case (ch)
            3'h0: level = 12'hFFF;
            3'h1: level = 12'h800;
            3'h2: level = 12'h7FF;
            3'h3: level = 12'h001;
            3'h4: level = 12'hA5C;
            3'h5: level = 12'h35A;
            3'h6: level = 12'h123;
            default: level = 12'h000;
        endcase
    endfunction

    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end

    // Floating result line shows a changing pattern, never the last bit
    always @(posedge clock_i) pat <= ~pat;
    assign dout_w = dout_oe_n_o ? pat : dout_o;
    // Sample cap takes the routed input when tracking ends
    always @(negedge track_o) begin
        for (int i = 0; i < 7; i++) if (ain_sel_o[i]) held = level(3'(i));
        if (gnd_sel_o) held = 12'h000;
    end
    // Half-LSB offset puts code steps midway between integer values
    assign cmp = ({held, 1'b1} > {dac_code_o, 1'b0});
    always @(posedge clock_i) if (res_valid_o === 1'b1 && res_ready === 1'b1)
        got_q.push_back(res_data_o);

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        if (num_errors == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task automatic do_reset();
        sys_rst_i = 1'b1;
        repeat (12) @(posedge clock_i);
        #1;
        check({1'b0, dout_oe_n_o, power_up_o, track_o, gnd_sel_o, res_valid_o, res_full_o,
               overrun_o, ain_sel_o, dout_o}, 16'h4002);
        check(16'(dac_code_o), 16'h0000);
        sys_rst_i = 1'b0;
        exp_chan  = 3'h0;
        got_q.delete();
        str_q.delete();
        repeat (4) @(posedge clock_i);
        #1;
    endtask

    // Compares the popped stream with the expected results, in order
    task automatic cmp_stream();
        repeat (8) @(posedge clock_i);
        #1;
        check(16'(got_q.size()), 16'(str_q.size()));
        while (got_q.size() > 0 && str_q.size() > 0)
            check(16'(got_q.pop_front()), 16'(str_q.pop_front()));
        str_q.delete();
    endtask

    // Runs the queued words as one frame and judges every serial word
    task automatic frame(input bit low_idle);
        int n;
        n = wq.size();
        foreach (wq[i]) begin
            ser_q.push_back(asc_pkg::asc_result_t'({exp_chan, level(exp_chan)}));
            exp_chan = wq[i][5:3];
            host_u.ctrl_q.push_back(wq[i]);
        end
        wq.delete();
        host_u.run(n, low_idle, 16);
        while (host_u.rx_q.size() > 0) begin
            e = ser_q.pop_front();
            str_q.push_back(e);
            check(host_u.rx_q.pop_front(), {4'h0, e.code});
            check(host_u.trk_q.pop_front(), 16'hE000);
            check(host_u.pwr_q.pop_front(), 16'hFFFE);
        end
        repeat (6) @(posedge clock_i);
        #1;
        check({14'h0, dout_oe_n_o, power_up_o}, 16'h0002);
        if (res_ready) cmp_stream();
    endtask

    task automatic t_first();
        wq.push_back(8'hD7);
        frame(1'b0);
    endtask

    task automatic t_codes();
        for (int c = 1; c < 9; c++) wq.push_back(8'(((c % 8) << 3) | ((c % 2) ? 8'hC7 : 8'h00)));
        frame(1'b0);
    endtask

    task automatic t_idle_low();
        wq.push_back(8'h18);
        wq.push_back(8'h30);
        frame(1'b1);
    endtask

    // Far side stalls: four results fill the buffer, a fifth waits
    task automatic t_fifo();
        res_ready = 1'b0;
        for (int c = 0; c < 5; c++) wq.push_back(8'(c << 3));
        frame(1'b0);
        check({13'h0, res_full_o, res_valid_o, overrun_o}, 16'h0006);
        check(16'(got_q.size()), 16'h0000);
        res_ready = 1'b1;
        cmp_stream();
        check(16'(res_valid_o), 16'h0000);
    endtask

    task automatic t_abort();
        host_u.ctrl_q.push_back(8'h38);
        host_u.run(1, 1'b0, 5);
        repeat (6) @(posedge clock_i);
        #1;
        check({14'h0, dout_oe_n_o, power_up_o}, 16'h0002);
        check(16'(got_q.size()), 16'h0000);
    endtask

    // Sixth result overwrites the waiting fifth one
    task automatic t_overrun();
        res_ready = 1'b0;
        for (int c = 0; c < 6; c++) wq.push_back(8'((c + 1) << 3));
        frame(1'b0);
        check(16'(overrun_o), 16'h0001);
        res_ready = 1'b1;
        str_q.delete(4);
        cmp_stream();
    endtask

    initial begin
        sys_rst_i = 1'b1;
        res_ready = 1'b1;
        pat       = 1'b0;
        do_reset();
        t_first();
        t_codes();
        t_idle_low();
        t_fifo();
        t_abort();
        do_reset();
        t_first();
        t_overrun();
        end_of_test();
    end

    // Run needs about 3200 clocks; a hang is cut short well beyond that
    initial begin
        repeat (30000) @(posedge clock_i);
        num_errors++;
        end_of_test();
    end
endmodule

`default_nettype wire
